// >>> link_auth_interrupt_ctl.v
// Interrupt enable and event status logic of the link transmitter.
// Assumes a byte register port from the serial control bus slave on the
// same clock; event inputs from the engines are same-clock pulses, while
// the remote interrupt and the receiver lock come from pins.
//
// Behaviour
// - Indirect access completion sets status bit 7; interrupts when enable 7.
// - Receiver detection sets status bit 6; interrupts when enable 6.
// - With lock-wait select at 1, detection waits for receiver lock.
// - Downstream interrupt request sets status bit 5; forwarded when enable 5.
// - Key list ready sets status bit 4; interrupts when enable 4.
// - Key vector ready sets status bit 3; interrupts when enable 3.
// - Authentication failure or loss sets status bit 2; enable 2 gates it.
// - Authentication pass sets status bit 1; enable 1 gates it.
// - Interrupt output only drives while global enable bit 0 is set.
// - Status bit 0 is the OR of enabled pending sources.
// - Remote interrupt input is active low; low means pending.
// - Key vector ready holds until controller writes key-accepted, which clears it.
`timescale 1ns/100ps
`include "link_auth_irq_defs.vh"
module link_auth_interrupt_ctl (
    // Clock and reset
    input  wire       clock,
    input  wire       rstn,
    // Register port
    input  wire [7:0] reg_addr,
    input  wire       reg_wr,
    input  wire       reg_rd,
    input  wire [7:0] reg_wdata,
    output reg  [7:0] reg_rdata_ff,
    // Configuration from the protection config register
    input  wire       detect_waits_lock_sel,
    // Engine events, one-cycle pulses
    input  wire       indirect_done_evt,
    input  wire       receiver_found_evt,
    input  wire       key_list_ready_evt,
    input  wire       key_vector_ready_evt,
    input  wire       auth_failed_evt,
    input  wire       auth_passed_evt,
    // Controller write of the key-accepted control bit, one-cycle pulse
    input  wire       key_vector_accepted,
    // Pins from the downstream receiver
    input  wire       remote_irq_input_n,
    input  wire       receiver_lock,
    // Interrupt to the controller, active low
    output reg        irq_out_n_ff,
    // Held key vector ready for the authentication engine
    output reg        key_vector_wait_ff
);
    // Register storage, next values and decode
    reg  [7:0] interrupt_enable_ctl_ff;
    reg  [7:1] interrupt_event_status_ff;
    reg        detect_state_ff;
    reg        remote_prev_ff;
    reg        nxt_detect_state;
    reg        nxt_found_from_lock;
    reg  [7:0] nxt_rdata;
    wire [7:1] nxt_event;
    wire [1:0] pin_sync;
    wire       remote_pend;
    wire       lock_sync;
    wire [7:1] raw_evt;
    wire [7:1] enabled_pending;
    wire       any_enabled;
    wire       enable_sel;
    wire       status_sel;
    wire       enable_wr;
    wire       stat_read;
    wire       found_now;

    // Receiver-detect states: idle, or detection seen and lock awaited
    localparam DETECT_IDLE      = 1'h0;
    localparam DETECT_WAIT_LOCK = 1'h1;

    // Both pins pass two flops before any logic reads them.
    // The remote line idles high, so its stage resets high: no false edge.
    pin_sync2 #(
        .WIDTH   (2),
        .RST_VAL (2'h2)
    ) i_pin_sync2 (
        .clock    (clock),
        .rstn     (rstn),
        .async_in ({remote_irq_input_n, receiver_lock}),
        .sync_out (pin_sync)
    );
    assign remote_pend = ~pin_sync[1];
    assign lock_sync   = pin_sync[0];

    // Register port decode; other addresses are refused
    assign enable_sel = (reg_addr == `IRQ_ENABLE_CTL_ADDR);
    assign status_sel = (reg_addr == `IRQ_EVENT_STATUS_ADDR);
    assign enable_wr  = reg_wr && enable_sel;
    assign stat_read  = reg_rd && status_sel;

    // Receiver-detect deferral; with select low detection passes straight.
    // Only one deferred detection is remembered; repeats while waiting merge.
    always @* begin
        nxt_detect_state    = detect_state_ff;
        nxt_found_from_lock = 1'h0;
        case (detect_state_ff)
            DETECT_IDLE: begin
                if (receiver_found_evt && detect_waits_lock_sel && !lock_sync)
                    nxt_detect_state = DETECT_WAIT_LOCK;
            end
            DETECT_WAIT_LOCK: begin
                if (!detect_waits_lock_sel) begin
                    // Select dropped: the deferred detection is abandoned
                    nxt_detect_state = DETECT_IDLE;
                end else if (lock_sync) begin
                    nxt_detect_state    = DETECT_IDLE;
                    nxt_found_from_lock = 1'h1;
                end
            end
            default: begin
                nxt_detect_state = DETECT_IDLE;
            end
        endcase
    end

    // Detection counts at once unless it must wait for lock
    assign found_now = receiver_found_evt && (!detect_waits_lock_sel || lock_sync);

    // Raw one-cycle events per status bit
    assign raw_evt[`BIT_INDIRECT_DONE]    = indirect_done_evt;
    assign raw_evt[`BIT_RECEIVER_FOUND]   = found_now || nxt_found_from_lock;
    assign raw_evt[`BIT_DOWNSTREAM_IRQ]   = remote_pend && !remote_prev_ff;
    assign raw_evt[`BIT_KEY_LIST_READY]   = key_list_ready_evt;
    assign raw_evt[`BIT_KEY_VECTOR_READY] = key_vector_ready_evt;
    assign raw_evt[`BIT_AUTH_FAILED]      = auth_failed_evt;
    assign raw_evt[`BIT_AUTH_PASSED]      = auth_passed_evt;

    // Sticky status: read clears, but an event in the same cycle wins,
    // so an event landing on the read is reported by the next read
    genvar gi;
    generate
        for (gi = 1; gi < 8; gi = gi + 1) begin : g_evt
            assign nxt_event[gi] = raw_evt[gi] ||
                                   (interrupt_event_status_ff[gi] && !stat_read);
        end
    endgenerate

    // Per-source gating by the individual enables
    assign enabled_pending = interrupt_event_status_ff & interrupt_enable_ctl_ff[7:1];
    // Global status ignores the global enable; only the pin is gated by it
    assign any_enabled = |enabled_pending;

    // Read data mux; zero when idle so a stale byte never lingers
    always @* begin
        nxt_rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                `IRQ_ENABLE_CTL_ADDR: begin
                    nxt_rdata = interrupt_enable_ctl_ff;
                end
                `IRQ_EVENT_STATUS_ADDR: begin
                    nxt_rdata = {interrupt_event_status_ff, any_enabled};
                end
                default: begin
                    nxt_rdata = 8'h00;
                end
            endcase
        end
    end

    // Enable register, written only at its own address
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            interrupt_enable_ctl_ff <= `IRQ_ENABLE_CTL_RST;
        end else if (enable_wr) begin
            interrupt_enable_ctl_ff <= reg_wdata;
        end
    end

    // Status flags; host writes to the status address are ignored
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            interrupt_event_status_ff <= `IRQ_EVENT_FLAGS_RST;
        end else begin
            interrupt_event_status_ff <= nxt_event;
        end
    end

    // Receiver-detect state and remote edge history
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            detect_state_ff <= DETECT_IDLE;
            remote_prev_ff  <= 1'h0;
        end else begin
            detect_state_ff <= nxt_detect_state;
            remote_prev_ff  <= remote_pend;
        end
    end

    // Read data stands for one cycle after the strobe
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            reg_rdata_ff <= 8'h00;
        end else begin
            reg_rdata_ff <= nxt_rdata;
        end
    end

    // Interrupt pin, active low, one cycle behind the status bits.
    // Registered so the pin never glitches while several sources change.
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            irq_out_n_ff <= 1'h1;
        end else begin
            irq_out_n_ff <= ~(interrupt_enable_ctl_ff[`BIT_GLOBAL] && any_enabled);
        end
    end

    // Key vector ready held until accepted; a new ready beats the accept,
    // so a vector arriving with a late accept is never lost
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            key_vector_wait_ff <= 1'h0;
        end else if (key_vector_ready_evt) begin
            key_vector_wait_ff <= 1'h1;
        end else if (key_vector_accepted) begin
            key_vector_wait_ff <= 1'h0;
        end
    end
endmodule // link_auth_interrupt_ctl

// >>> link_auth_irq_defs.vh
// Register offsets, field positions and reset values for the
// authentication interrupt controller. Definitions only.
`ifndef LINK_AUTH_IRQ_DEFS_VH
`define LINK_AUTH_IRQ_DEFS_VH

// Register offsets on the serial control bus register port
`define IRQ_ENABLE_CTL_ADDR   8'hC6
`define IRQ_EVENT_STATUS_ADDR 8'hC7

// Reset values
`define IRQ_ENABLE_CTL_RST    8'h00
`define IRQ_EVENT_STATUS_RST  8'h00
// Stored event flags only, bits 7..1; bit 0 is computed on read
`define IRQ_EVENT_FLAGS_RST   7'h00

// Bit positions, shared by enable and status registers
`define BIT_INDIRECT_DONE     7
`define BIT_RECEIVER_FOUND    6
`define BIT_DOWNSTREAM_IRQ    5
`define BIT_KEY_LIST_READY    4
`define BIT_KEY_VECTOR_READY  3
`define BIT_AUTH_FAILED       2
`define BIT_AUTH_PASSED       1
`define BIT_GLOBAL            0

`endif

// >>> pin_sync2.v
// Two flip-flop synchroniser for pin-level inputs.
// Assumes the input is asynchronous to clock.
`timescale 1ns/100ps
module pin_sync2 #(
    parameter             WIDTH   = 1,
    // Idle level of each pin; a parameter keeps the reset branch constant
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
    // Clock and reset
    input  wire             clock,
    input  wire             rstn,
    // Data
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_ff;
    reg [WIDTH-1:0] sync_ff;

    // First stage feeds only the second; reset to idle, so no false edge
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            meta_ff <= RST_VAL;
            sync_ff <= RST_VAL;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule // pin_sync2

// >>> host_ctl_model.sv
// Host controller model: byte reads and writes on the register port.
// Assumes every task is entered at a falling edge and ends at one.
`timescale 1ns/100ps
module host_ctl_model (
    // Clock
    input  wire logic       clock,
    // Register port
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata_ff
);
    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h00000;
    end
    // One-cycle strobe, so a read may follow in the very next cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
        @(negedge clock);
        reg_wr = 1'b0;
    endtask
    // Read data is registered: taken one edge after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        {reg_addr, reg_rd} = {a, 1'b1};
        @(negedge clock);
        reg_rd = 1'b0;
        q = reg_rdata_ff;
    endtask
endmodule // host_ctl_model

// >>> link_auth_interrupt_ctl_assertions.sv
// Port checks of the interrupt controller.
// Assumes binding to link_auth_interrupt_ctl.
`timescale 1ns/100ps
module irq_ctl_checks (
    input wire logic       clock, rstn, reg_wr, reg_rd, irq_out_n_ff,
    input wire logic       auth_passed_evt, key_vector_ready_evt,
    input wire logic       key_vector_accepted, key_vector_wait_ff,
    input wire logic [7:0] reg_addr, reg_wdata, reg_rdata_ff
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    wire wr_en = reg_wr && reg_addr == 8'hC6;
    rd_idle_a: assert property (!reg_rd |=> reg_rdata_ff == 8'h00)
        else $error("read data not idle");
    rd_unmapped_a: assert property (reg_rd && reg_addr != 8'hC6 && reg_addr != 8'hC7
        |=> reg_rdata_ff == 8'h00) else $error("unmapped read");
    en_readback_a: assert property (wr_en ##1 reg_rd && reg_addr == 8'hC6 && !reg_wr
        |=> reg_rdata_ff == $past(reg_wdata, 2)) else $error("enable readback");
    global_off_a: assert property (wr_en && !reg_wdata[0] ##1 !wr_en |=> irq_out_n_ff)
        else $error("irq while global off");
    or_none_a: assert property (wr_en && reg_wdata == 8'h00 ##1 reg_rd && reg_addr == 8'hC7
        && !reg_wr |=> !reg_rdata_ff[0]) else $error("global status set");
    pass_irq_a: assert property (wr_en && reg_wdata == 8'h03 ##1 auth_passed_evt && !reg_rd
        && !reg_wr |-> ##2 !irq_out_n_ff) else $error("pass irq missing");
    kv_set_a: assert property (key_vector_ready_evt |=> key_vector_wait_ff)
        else $error("key wait not set");
    kv_hold_a: assert property (key_vector_wait_ff && !key_vector_accepted
        |=> key_vector_wait_ff) else $error("key wait dropped");
endmodule // irq_ctl_checks
bind link_auth_interrupt_ctl irq_ctl_checks i_irq_ctl_checks (.clock, .rstn, .reg_wr,
    .reg_rd, .irq_out_n_ff, .auth_passed_evt, .key_vector_ready_evt, .key_vector_accepted,
    .key_vector_wait_ff, .reg_addr, .reg_wdata, .reg_rdata_ff);

// >>> link_auth_interrupt_ctl_bench.sv
// Self-checking bench of the interrupt controller.
// Assumes the host model drives the register port at falling edges.
`timescale 1ns/100ps
module link_auth_interrupt_ctl_bench;
    logic       clock = 1'b0, rstn = 1'b0, sel = 1'b0, acc = 1'b0, rirq_n = 1'b1, lock = 1'b0;
    logic [7:0] ev = 8'h00, q, reg_addr, reg_wdata, reg_rdata_ff;
    logic       reg_wr, reg_rd, irq_n, kv_wait;
    int         failures = 0, n_checks = 0;
    always #5 clock = ~clock;
    host_ctl_model i_host_ctl_model (.clock, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata_ff);
    link_auth_interrupt_ctl i_link_auth_interrupt_ctl (.clock, .rstn, .reg_addr, .reg_wr,
        .reg_rd, .reg_wdata, .reg_rdata_ff, .detect_waits_lock_sel(sel),
        .indirect_done_evt(ev[7]), .receiver_found_evt(ev[6]), .key_list_ready_evt(ev[4]),
        .key_vector_ready_evt(ev[3]), .auth_failed_evt(ev[2]), .auth_passed_evt(ev[1]),
        .key_vector_accepted(acc), .remote_irq_input_n(rirq_n), .receiver_lock(lock),
        .irq_out_n_ff(irq_n), .key_vector_wait_ff(kv_wait));
    // Pin levels have their own compare
    task automatic chk_pin(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t pin got %b want %b", $time, got, exp);
        end
    endtask
    // Register bytes
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        i_host_ctl_model.rd(a, q);
        chk(q, exp);
    endtask
    task automatic pulse(input logic [7:0] e);
        ev = e;
        @(negedge clock);
        ev = 8'h00;
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(negedge clock);
    endtask
    // Reset values, read-back, refused status write, unmapped read
    task automatic regs_test;
        rd_chk(8'hC6, 8'h00);
        i_host_ctl_model.wr(8'hC6, 8'hA4);
        rd_chk(8'hC6, 8'hA4);
        i_host_ctl_model.wr(8'hC7, 8'hFF);
        rd_chk(8'hC7, 8'h00);
        wait_n(1);
        rd_chk(8'hC5, 8'h00);
    endtask
    // One source: fully enabled, global off, then source off
    task automatic event_test(input int b);
        logic [7:0] m;
        m = 8'h01 << b;
        i_host_ctl_model.wr(8'hC6, m | 8'h01);
        pulse(m);
        wait_n(2);
        chk_pin(irq_n, 1'b0);
        rd_chk(8'hC7, m | 8'h01);
        wait_n(1);
        chk_pin(irq_n, 1'b1);
        i_host_ctl_model.wr(8'hC6, m);
        pulse(m);
        wait_n(2);
        chk_pin(irq_n, 1'b1);
        rd_chk(8'hC7, m | 8'h01);
        i_host_ctl_model.wr(8'hC6, 8'h01);
        pulse(m);
        rd_chk(8'hC7, m);
    endtask
    // Remote pin pulled low; status bit latches the request
    task automatic remote_test;
        i_host_ctl_model.wr(8'hC6, 8'h21);
        rirq_n = 1'b0;
        wait_n(6);
        chk_pin(irq_n, 1'b0);
        rd_chk(8'hC7, 8'h21);
        rirq_n = 1'b1;
    endtask
    // Detection held back until the receiver reports lock
    task automatic lock_test;
        sel = 1'b1;
        i_host_ctl_model.wr(8'hC6, 8'h00);
        rd_chk(8'hC7, 8'h00);
        pulse(8'h40);
        wait_n(2);
        rd_chk(8'hC7, 8'h00);
        lock = 1'b1;
        wait_n(5);
        rd_chk(8'hC7, 8'h40);
    endtask
    // Key vector ready stands until accepted; a ready with an accept wins
    task automatic key_test;
        acc = 1'b1;
        wait_n(1);
        acc = 1'b0;
        chk_pin(kv_wait, 1'b0);
        pulse(8'h08);
        wait_n(3);
        chk_pin(kv_wait, 1'b1);
        acc = 1'b1;
        wait_n(1);
        acc = 1'b0;
        chk_pin(kv_wait, 1'b0);
        wait_n(1);
        acc = 1'b1;
        pulse(8'h08);
        acc = 1'b0;
        chk_pin(kv_wait, 1'b1);
    endtask
    task automatic final_report;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clock);
        @(negedge clock);
        rstn = 1'b1;
        wait_n(3);
        regs_test;
        event_test(7);
        event_test(6);
        event_test(4);
        event_test(3);
        event_test(2);
        event_test(1);
        remote_test;
        lock_test;
        key_test;
        final_report;
    end
endmodule // link_auth_interrupt_ctl_bench
